// ==== core/serport_defines.svh ====
// Register offsets, field positions and reset values of the serial port
`ifndef SERPORT_DEFINES_SVH
`define SERPORT_DEFINES_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define OFS_RELOAD   8'h00
`define OFS_BUF      8'h04
`define OFS_CTL1     8'h08
`define OFS_CTL2     8'h0C
`define OFS_STAT     8'h10
`define OFS_IRQ_ST   8'h14
`define OFS_IRQ_MASK 8'h18

// ----------------------------------------
// Field positions
// ----------------------------------------
`define CTL1_WRITE_COLLISION_FLAG    7
`define CTL1_EN      5
`define CTL2_STOP    2
`define STAT_STOP    4
`define STAT_BF      0
`define IRQ_EVT      0
`define IRQ_BCL      1

// ----------------------------------------
// Modes, reset values and the index of the last byte-clock edge
// ----------------------------------------
`define MODE_I2C_MST 4'h8
`define MODE_SPI_MST 4'hA
`define RST_RELOAD   8'h00
`define RST_MODE     4'h0
`define XFER_EDGES   4'hF

`endif

// ==== core/serport_pkg.sv ====
// Types shared by the serial port design
package serport_pkg;

  typedef enum logic [2:0] {
    ST_IDLE     = 3'b000,
    ST_XFER     = 3'b001,
    ST_SDA_LOW  = 3'b010,
    ST_WAIT     = 3'b011,
    ST_SCL_REL  = 3'b100,
    ST_SCL_HIGH = 3'b101,
    ST_SDA_REL  = 3'b110,
    ST_DONE     = 3'b111
  } port_state_t;

endpackage

// ==== core/pin_sync3.sv ====
// Three-stage pin synchroniser that accepts a level once stages two and three agree
`timescale 1ns/10ps
module pin_sync3 #(
  parameter logic RST_VAL = 1'b1
) (
  input  wire logic clk,
  input  wire logic arst_n,
  input  wire logic pin,
  output logic      level
);

  logic s1_ff;
  logic s2_ff;
  logic s3_ff;
  logic lvl_ff;
  logic nxt_lvl;

  always_comb begin
    nxt_lvl = (s2_ff == s3_ff) ? s3_ff : lvl_ff;
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s1_ff  <= RST_VAL;
      s2_ff  <= RST_VAL;
      s3_ff  <= RST_VAL;
      lvl_ff <= RST_VAL;
    end else begin
      s1_ff  <= pin;
      s2_ff  <= s1_ff;
      s3_ff  <= s2_ff;
      lvl_ff <= nxt_lvl;
    end
  end

  assign level = lvl_ff;

endmodule

// ==== core/rate_counter.sv ====
// Reload down-counter that times each half period of the serial clock
`timescale 1ns/10ps
module rate_counter #(
  parameter int WIDTH = 8
) (
  input  wire logic             clk,
  input  wire logic             arst_n,
  input  wire logic             load,
  input  wire logic             run,
  input  wire logic [WIDTH-1:0] reload,
  output logic                  expire,
  output logic      [WIDTH-1:0] count
);

  logic             pre_ff;
  logic [WIDTH-1:0] cnt_ff;
  logic             nxt_pre;
  logic [WIDTH-1:0] nxt_cnt;

  // Steps on every second core clock so one half period is 2*(reload+1) clocks
  always_comb begin
    expire  = run && pre_ff && (cnt_ff == '0);
    nxt_pre = run ? ~pre_ff : 1'b0;
    nxt_cnt = cnt_ff;
    if (load) begin
      nxt_cnt = reload;
      nxt_pre = 1'b0;
    end else if (run && pre_ff) begin
      nxt_cnt = (cnt_ff == '0) ? reload : cnt_ff - 1'b1;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pre_ff <= 1'b0;
      cnt_ff <= '0;
    end else begin
      pre_ff <= nxt_pre;
      cnt_ff <= nxt_cnt;
    end
  end

  assign count = cnt_ff;

endmodule

// ==== core/i2c_stop_collision_baud_gen.sv ====
// Serial port master: rate generator, byte clocking and Stop with collision checks
//
// Added by the designer: the register offsets and the APB register port.
`timescale 1ns/10ps
`include "serport_defines.svh"

module i2c_stop_collision_baud_gen
  import serport_pkg::*;
(
  input  wire logic        CORE_CLK,
  input  wire logic        ARST_N,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  output logic             IRQ,
  input  wire logic        SDA_IN,
  output logic             SDA_OUT,
  output logic             SDA_OE_N,
  input  wire logic        SCL_IN,
  output logic             SCL_OUT,
  output logic             SCL_OE_N
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  port_state_t state_ff,    nxt_state;
  logic [7:0]  reload_ff,   nxt_reload;
  logic [7:0]  buf_ff,      nxt_buf;
  logic        write_collision_flag_ff,     nxt_write_collision_flag;
  logic        en_ff,       nxt_en;
  logic [3:0]  mode_ff,     nxt_mode;
  logic        stop_req_ff, nxt_stop_req;
  logic        stop_seen_ff, nxt_stop_seen;
  logic [1:0]  irq_st_ff,   nxt_irq_st;
  logic [1:0]  irq_mask_ff, nxt_irq_mask;
  logic [7:0]  shift_ff,    nxt_shift;
  logic [3:0]  edge_ff,     nxt_edge;
  logic        lvl_ff,      nxt_lvl;
  logic [31:0] prdata_ff,   nxt_prdata;
  logic        pready_ff,   nxt_pready;
  logic        pslverr_ff,  nxt_pslverr;
  logic        irq_ff,      nxt_irq;
  logic        sda_out_ff,  nxt_sda_out;
  logic        sda_oe_n_ff, nxt_sda_oe_n;
  logic        scl_out_ff,  nxt_scl_out;
  logic        scl_oe_n_ff, nxt_scl_oe_n;

  logic        sda_i;
  logic        scl_i;
  logic        cnt_load;
  logic        cnt_run;
  logic        expire;
  logic [7:0]  cnt_val;
  logic        wr;
  logic        rd;
  logic        buf_wr;
  logic        is_i2c;
  logic        is_spi;
  logic        in_stop;
  logic        bcl_set;
  logic        evt_set;
  logic        write_collision_flag_set;

  // ----------------------------------------
  // Pin synchronisers and rate counter
  // ----------------------------------------
  pin_sync3 #(.RST_VAL(1'b1)) u_sda_sync (
    .clk    (CORE_CLK),
    .arst_n (ARST_N),
    .pin    (SDA_IN),
    .level  (sda_i)
  );

  pin_sync3 #(.RST_VAL(1'b1)) u_scl_sync (
    .clk    (CORE_CLK),
    .arst_n (ARST_N),
    .pin    (SCL_IN),
    .level  (scl_i)
  );

  // Shared by both master modes; stands still while idle
  rate_counter #(.WIDTH(8)) u_rate (
    .clk    (CORE_CLK),
    .arst_n (ARST_N),
    .load   (cnt_load),
    .run    (cnt_run),
    .reload (reload_ff),
    .expire (expire),
    .count  (cnt_val)
  );

  // ----------------------------------------
  // Decode
  // ----------------------------------------
  // A transfer completes on the edge where pready_ff is already high
  assign wr      = PSEL && PENABLE && pready_ff && PWRITE;
  assign rd      = PSEL && PENABLE && pready_ff && !PWRITE;
  assign buf_wr  = wr && (PADDR == `OFS_BUF);
  assign is_i2c  = (mode_ff == `MODE_I2C_MST);
  assign is_spi  = (mode_ff == `MODE_SPI_MST);
  assign in_stop = (state_ff != ST_IDLE) && (state_ff != ST_XFER);
  assign cnt_run = (state_ff != ST_IDLE) && (state_ff != ST_SDA_LOW);

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    nxt_state     = state_ff;
    nxt_reload    = reload_ff;
    nxt_buf       = buf_ff;
    nxt_en        = en_ff;
    nxt_mode      = mode_ff;
    nxt_stop_req  = stop_req_ff;
    nxt_stop_seen = stop_seen_ff;
    nxt_irq_mask  = irq_mask_ff;
    nxt_shift     = shift_ff;
    nxt_edge      = edge_ff;
    nxt_lvl       = lvl_ff;
    nxt_sda_out   = sda_out_ff;
    nxt_sda_oe_n  = sda_oe_n_ff;
    nxt_scl_out   = scl_out_ff;
    nxt_scl_oe_n  = scl_oe_n_ff;
    cnt_load      = 1'b0;
    bcl_set       = 1'b0;
    evt_set       = 1'b0;
    write_collision_flag_set      = 1'b0;

    // APB answer one cycle into the access phase
    nxt_pready  = PSEL && PENABLE && !pready_ff;
    nxt_prdata  = prdata_ff;
    nxt_pslverr = pslverr_ff;
    if (PSEL && PENABLE && !pready_ff) begin
      nxt_pslverr = 1'b0;
      nxt_prdata  = 32'h0000_0000;
      case (PADDR)
        `OFS_RELOAD:   nxt_prdata[7:0] = reload_ff;
        `OFS_BUF:      nxt_prdata[7:0] = buf_ff;
        `OFS_CTL1:     nxt_prdata[7:0] = {write_collision_flag_ff, 1'b0, en_ff, 1'b0, mode_ff};
        `OFS_CTL2:     nxt_prdata[`CTL2_STOP] = stop_req_ff;
        `OFS_STAT: begin
          nxt_prdata[`STAT_STOP] = stop_seen_ff;
          nxt_prdata[`STAT_BF]   = (state_ff == ST_XFER);
        end
        `OFS_IRQ_ST:   nxt_prdata[1:0] = irq_st_ff;
        `OFS_IRQ_MASK: nxt_prdata[1:0] = irq_mask_ff;
        default:       nxt_pslverr = 1'b1;
      endcase
    end

    // Register writes
    if (wr) begin
      case (PADDR)
        `OFS_RELOAD:   nxt_reload = PWDATA[7:0];
        `OFS_CTL1: begin
          nxt_en   = PWDATA[`CTL1_EN];
          nxt_mode = PWDATA[3:0];
        end
        `OFS_IRQ_MASK: nxt_irq_mask = PWDATA[1:0];
        default: ;
      endcase
    end
    if (buf_wr && (state_ff == ST_IDLE)) begin
      nxt_buf = PWDATA[7:0];
    end else if (buf_wr) begin
      write_collision_flag_set = 1'b1;
    end

    // Port sequencer
    unique case (state_ff)
      ST_IDLE: begin
        if (en_ff && is_i2c && stop_req_ff) begin
          nxt_state    = ST_SDA_LOW;
          nxt_sda_out  = 1'b0;
          nxt_sda_oe_n = 1'b0;
          nxt_scl_out  = 1'b0;
          nxt_scl_oe_n = 1'b0;
        end else if (buf_wr && en_ff && (is_i2c || is_spi)) begin
          nxt_state = ST_XFER;
          nxt_shift = PWDATA[7:0];
          nxt_edge  = 4'h0;
          nxt_lvl   = 1'b0;
          cnt_load  = 1'b1;
        end
      end
      ST_XFER: begin
        if (expire) begin
          nxt_lvl  = ~lvl_ff;
          nxt_edge = edge_ff + 4'h1;
          if (lvl_ff) begin
            nxt_shift = {shift_ff[6:0], 1'b0};
          end
          if (edge_ff == `XFER_EDGES) begin
            nxt_state = ST_IDLE;
          end
        end
      end
      ST_SDA_LOW: begin
        if (!sda_i) begin
          nxt_state = ST_WAIT;
          cnt_load  = 1'b1;
        end
      end
      ST_WAIT: begin
        if (expire) begin
          nxt_state    = ST_SCL_REL;
          nxt_scl_oe_n = 1'b1;
        end
      end
      ST_SCL_REL: begin
        // Another party may stretch the clock here
        if (scl_i) begin
          nxt_state = ST_SCL_HIGH;
          cnt_load  = 1'b1;
        end
      end
      ST_SCL_HIGH: begin
        if (!scl_i) begin
          bcl_set = 1'b1;
        end else if (expire) begin
          nxt_state    = ST_SDA_REL;
          nxt_sda_oe_n = 1'b1;
          cnt_load     = 1'b1;
        end
      end
      ST_SDA_REL: begin
        if (!scl_i && !sda_i) begin
          bcl_set = 1'b1;
        end else if (expire) begin
          if (sda_i && scl_i) begin
            nxt_state     = ST_DONE;
            nxt_stop_seen = 1'b1;
            cnt_load      = 1'b1;
          end else begin
            bcl_set = 1'b1;
          end
        end
      end
      ST_DONE: begin
        if (expire) begin
          nxt_state    = ST_IDLE;
          nxt_stop_req = 1'b0;
          evt_set      = 1'b1;
        end
      end
    endcase

    if (bcl_set) begin
      nxt_state    = ST_IDLE;
      nxt_stop_req = 1'b0;
      nxt_sda_oe_n = 1'b1;
      nxt_scl_oe_n = 1'b1;
    end

    // Byte clocking, last fall included so the clock ends low; I2C lines are open drain
    if ((nxt_state == ST_XFER) || (state_ff == ST_XFER)) begin
      if (is_i2c) begin
        nxt_scl_out  = 1'b0;
        nxt_scl_oe_n = nxt_lvl;
        nxt_sda_out  = 1'b0;
        nxt_sda_oe_n = nxt_shift[7];
      end else begin
        nxt_scl_out  = nxt_lvl;
        nxt_scl_oe_n = 1'b0;
        nxt_sda_out  = nxt_shift[7];
        nxt_sda_oe_n = 1'b0;
      end
    end

    // Software sets the request; applied after the clear so a new set survives
    if (wr && (PADDR == `OFS_CTL2) && PWDATA[`CTL2_STOP]) begin
      nxt_stop_req = 1'b1;
    end
    if (!nxt_en) begin
      nxt_stop_seen = 1'b0;
    end

    // Write collision clears by writing zero; a new hit wins
    nxt_write_collision_flag = write_collision_flag_ff;
    if (wr && (PADDR == `OFS_CTL1) && !PWDATA[`CTL1_WRITE_COLLISION_FLAG]) begin
      nxt_write_collision_flag = 1'b0;
    end
    nxt_write_collision_flag = nxt_write_collision_flag | write_collision_flag_set;

    // Read clears only the bits that the read returned
    nxt_irq_st = irq_st_ff;
    if (rd && (PADDR == `OFS_IRQ_ST)) begin
      nxt_irq_st = irq_st_ff & ~prdata_ff[1:0];
    end
    nxt_irq_st[`IRQ_EVT] = nxt_irq_st[`IRQ_EVT] | evt_set;
    nxt_irq_st[`IRQ_BCL] = nxt_irq_st[`IRQ_BCL] | bcl_set;
    nxt_irq = |(nxt_irq_st & nxt_irq_mask);
  end

  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      state_ff     <= ST_IDLE;
      reload_ff    <= `RST_RELOAD;
      buf_ff       <= 8'h00;
      write_collision_flag_ff      <= 1'b0;
      en_ff        <= 1'b0;
      mode_ff      <= `RST_MODE;
      stop_req_ff  <= 1'b0;
      stop_seen_ff <= 1'b0;
      irq_st_ff    <= 2'h0;
      irq_mask_ff  <= 2'h0;
      shift_ff     <= 8'h00;
      edge_ff      <= 4'h0;
      lvl_ff       <= 1'b0;
      prdata_ff    <= 32'h0000_0000;
      pready_ff    <= 1'b0;
      pslverr_ff   <= 1'b0;
      irq_ff       <= 1'b0;
      sda_out_ff   <= 1'b0;
      sda_oe_n_ff  <= 1'b1;
      scl_out_ff   <= 1'b0;
      scl_oe_n_ff  <= 1'b1;
    end else begin
      state_ff     <= nxt_state;
      reload_ff    <= nxt_reload;
      buf_ff       <= nxt_buf;
      write_collision_flag_ff      <= nxt_write_collision_flag;
      en_ff        <= nxt_en;
      mode_ff      <= nxt_mode;
      stop_req_ff  <= nxt_stop_req;
      stop_seen_ff <= nxt_stop_seen;
      irq_st_ff    <= nxt_irq_st;
      irq_mask_ff  <= nxt_irq_mask;
      shift_ff     <= nxt_shift;
      edge_ff      <= nxt_edge;
      lvl_ff       <= nxt_lvl;
      prdata_ff    <= nxt_prdata;
      pready_ff    <= nxt_pready;
      pslverr_ff   <= nxt_pslverr;
      irq_ff       <= nxt_irq;
      sda_out_ff   <= nxt_sda_out;
      sda_oe_n_ff  <= nxt_sda_oe_n;
      scl_out_ff   <= nxt_scl_out;
      scl_oe_n_ff  <= nxt_scl_oe_n;
    end
  end

  assign PRDATA   = prdata_ff;
  assign PREADY   = pready_ff;
  assign PSLVERR  = pslverr_ff;
  assign IRQ      = irq_ff;
  assign SDA_OUT  = sda_out_ff;
  assign SDA_OE_N = sda_oe_n_ff;
  assign SCL_OUT  = scl_out_ff;
  assign SCL_OE_N = scl_oe_n_ff;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  logic [8:0] gap_ff;

  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      gap_ff <= 9'h000;
    end else begin
      gap_ff <= (cnt_load || expire) ? 9'h000 : gap_ff + 9'h001;
    end
  end

  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!ARST_N);

  sda_sample_a: assert property (
    (state_ff == ST_SDA_REL) && expire && !sda_i |=> (state_ff == ST_IDLE) && irq_st_ff[`IRQ_BCL])
    else $error("low SDA after release not flagged");
  scl_early_a: assert property (
    (state_ff == ST_SCL_HIGH) && !scl_i |=> (state_ff == ST_IDLE) && irq_st_ff[`IRQ_BCL])
    else $error("SCL low during Stop not flagged");
  sda_first_a: assert property (
    (state_ff == ST_SDA_LOW) && sda_i |=> (state_ff == ST_SDA_LOW) && !SCL_OE_N)
    else $error("SCL released before SDA seen low");
  scl_high_load_a: assert property (
    (state_ff == ST_SCL_REL) && scl_i |=> (state_ff == ST_SCL_HIGH) && (cnt_val == reload_ff))
    else $error("counter not loaded on SCL high");
  auto_start_a: assert property (
    (state_ff == ST_IDLE) && buf_wr && en_ff && is_spi |=> (state_ff == ST_XFER))
    else $error("buffer write did not start clock");
  clock_hold_a: assert property (
    (state_ff == ST_IDLE) [*2] |-> $stable(SCL_OUT) && $stable(SCL_OE_N) && !expire)
    else $error("clock pin moved while idle");
  twice_reload_a: assert property (
    (state_ff == ST_XFER) && expire && (edge_ff != `XFER_EDGES) |=> cnt_val == $past(reload_ff))
    else $error("counter not reloaded at half period");
  half_period_a: assert property (
    expire && $stable(reload_ff) |-> gap_ff == {reload_ff, 1'b1})
    else $error("half period not 2*(reload+1) clocks");
  bus_abort_a: assert property (
    bcl_set |=> (state_ff == ST_IDLE) && SDA_OE_N && SCL_OE_N && !stop_req_ff)
    else $error("collision did not release lines");
  stop_done_a: assert property (
    (state_ff == ST_DONE) && expire |=> !stop_req_ff && irq_st_ff[`IRQ_EVT] && stop_seen_ff)
    else $error("Stop completion not reported");
  write_drop_a: assert property (
    in_stop && buf_wr |=> write_collision_flag_ff && $stable(buf_ff))
    else $error("buffer write during Stop not dropped");

  stop_ok_c: cover property ((state_ff == ST_DONE) && expire);
  stop_bcl_c: cover property (in_stop && bcl_set);
  spi_byte_c: cover property (is_spi && (state_ff == ST_XFER) ##1 (state_ff == ST_IDLE));
  i2c_byte_c: cover property (is_i2c && (state_ff == ST_XFER) ##1 (state_ff == ST_IDLE));

endmodule

// ==== verif/bus_peer.sv ====
// Far-side bus party: pull-ups, a rival master and clock stretching
`timescale 1ns/10ps
module bus_peer (
  input  wire logic       clk,
  input  wire logic [1:0] mode,
  input  wire logic       sda_out,
  input  wire logic       sda_oe_n,
  input  wire logic       scl_out,
  input  wire logic       scl_oe_n,
  output logic            sda_wire,
  output logic            scl_wire
);
  // ----------------------------------------
  // Wired-AND lines with pull-ups
  // ----------------------------------------
  int   st = 0;
  logic grip;
  logic pull;
  // Grip is the Stop window: clock released while data is still held low
  assign grip = scl_oe_n & ~sda_oe_n;
  // Mode 2 stretches the clock, mode 3 pulls it low shortly after release
  assign pull = grip & ((mode == 2'd2 && st < 30) || (mode == 2'd3 && st >= 4 && st < 16));
  // A released line floats to the pull-up level, never the last driven value
  assign sda_wire = (sda_oe_n | sda_out) & (mode != 2'd1);
  assign scl_wire = (scl_oe_n | scl_out) & ~pull;
  always @(posedge clk) begin
    if (mode == 2'd0) begin
      st <= 0;
    end else if (grip && st < 63) begin
      st <= st + 1;
    end
  end
endmodule

// ==== verif/i2c_stop_collision_baud_gen_tb.sv ====
// Self-checking bench: registers, serial clock rate and Stop collisions
`timescale 1ns/10ps
`include "serport_defines.svh"
module i2c_stop_collision_baud_gen_tb;
  logic        CORE_CLK   = 1'b0;
  logic        ARST_N     = 1'b0;
  logic        PSEL       = 1'b0;
  logic        PENABLE    = 1'b0;
  logic        PWRITE     = 1'b0;
  logic [7:0]  PADDR      = 8'h00;
  logic [31:0] PWDATA     = 32'h0;
  logic [31:0] PRDATA;
  logic        PREADY, PSLVERR, IRQ, SDA_OUT, SDA_OE_N, SCL_OUT, SCL_OE_N;
  logic        sda_w, scl_w, err;
  logic [1:0]  peer_mode  = 2'd0;
  logic        in_stop    = 1'b0;
  logic [31:0] rd;
  int          mismatches = 0;
  int          num_checks = 0;
  int          cyc, hi_at, gap;
  logic        scl_q      = 1'b1;
  logic        oe_q       = 1'b1;
  logic        sda_oe_q   = 1'b1;

  always #10 CORE_CLK = ~CORE_CLK;

  i2c_stop_collision_baud_gen dut (
    .CORE_CLK(CORE_CLK), .ARST_N(ARST_N), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
    .PREADY(PREADY), .PSLVERR(PSLVERR), .IRQ(IRQ), .SDA_IN(sda_w),
    .SDA_OUT(SDA_OUT), .SDA_OE_N(SDA_OE_N), .SCL_IN(scl_w), .SCL_OUT(SCL_OUT),
    .SCL_OE_N(SCL_OE_N));
  bus_peer peer (
    .clk(CORE_CLK), .mode(peer_mode), .sda_out(SDA_OUT), .sda_oe_n(SDA_OE_N),
    .scl_out(SCL_OUT), .scl_oe_n(SCL_OE_N), .sda_wire(sda_w), .scl_wire(scl_w));

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // One APB transfer; the slave's wait states are not assumed
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CORE_CLK);
    PENABLE <= 1'b1;
    do begin
      @(posedge CORE_CLK);
      n++;
    end while (PREADY !== 1'b1 && n < 20);
    if (n >= 20) mismatches++;
    rd = PRDATA;
    err = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    @(posedge CORE_CLK);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, {24'h0, d});
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(rd, exp);
  endtask

  task automatic wait_clear(input logic [7:0] a, input int b);
    int n;
    n = 0;
    do begin
      apb(1'b0, a, 32'h0);
      n++;
    end while (rd[b] !== 1'b0 && n < 200);
    check({31'h0, rd[b]}, 32'h0);
  endtask

  // Byte: period between clock rises on the wire, data sampled MSB first
  task automatic run_byte(input logic [7:0] d, input int per);
    int n;
    logic c, p;
    logic [7:0] sh;
    sh = 8'h00;
    wr(`OFS_BUF, d);
    c = scl_w;
    for (int k = 0; k < 8; k++) begin
      n = 0;
      do begin
        @(negedge CORE_CLK);
        p = c;
        c = scl_w;
        n++;
      end while (!(c && !p) && n < 400);
      sh = {sh[6:0], sda_w};
      if (k > 0) check(n, per);
    end
    check({24'h0, sh}, {24'h0, d});
    @(posedge CORE_CLK);
    wait_clear(`OFS_STAT, `STAT_BF);
    repeat (40) @(posedge CORE_CLK);
    check({31'h0, scl_w}, 32'h0);
  endtask

  task automatic run_stop(input logic [1:0] m);
    peer_mode <= m;
    in_stop <= 1'b1;
    wr(`OFS_CTL2, 8'h04);
    if (m == 2'd2) wr(`OFS_BUF, 8'h3C);
    wait_clear(`OFS_CTL2, `CTL2_STOP);
    in_stop <= 1'b0;
    peer_mode <= 2'd0;
    check({30'h0, SDA_OE_N, SCL_OE_N}, 32'h3);
  endtask

  // Watches the Stop order on the wire between clock edges
  always @(negedge CORE_CLK) begin
    cyc++;
    if (scl_w && !scl_q) hi_at = cyc;
    if (in_stop && SCL_OE_N && !oe_q) check({31'h0, sda_w}, 32'h0);
    if (in_stop && SDA_OE_N && !sda_oe_q) gap = cyc - hi_at;
    scl_q = scl_w;
    oe_q = SCL_OE_N;
    sda_oe_q = SDA_OE_N;
  end

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    // Whole run needs under a thousand cycles; this is ample margin
    #400000;
    mismatches++;
    conclude();
  end

  initial begin
    repeat (10) @(posedge CORE_CLK);
    ARST_N <= 1'b1;
    @(posedge CORE_CLK);
    for (int a = 0; a < 7; a++) rdchk(8'(a * 4), 32'h0);
    rdchk(8'h1C, 32'h0);
    check({31'h0, err}, 32'h1);
    wr(`OFS_STAT, 8'hFF);
    rdchk(`OFS_STAT, 32'h0);
    $display("test reset_map done");
    wr(`OFS_IRQ_MASK, 8'h03);
    wr(`OFS_RELOAD, 8'h03);
    wr(`OFS_CTL1, 8'h28);
    run_byte(8'hA5, 16);
    wr(`OFS_RELOAD, 8'h05);
    wr(`OFS_CTL1, 8'h2A);
    run_byte(8'h5A, 24);
    wr(`OFS_RELOAD, 8'h03);
    rdchk(`OFS_RELOAD, 32'h03);
    wr(`OFS_CTL1, 8'h28);
    $display("test rate done");
    run_stop(2'd1);
    check({31'h0, IRQ}, 32'h1);
    rdchk(`OFS_IRQ_ST, 32'h2);
    rdchk(`OFS_STAT, 32'h0);
    $display("test stop_sda_collision done");
    wr(`OFS_IRQ_MASK, 8'h00);
    run_stop(2'd3);
    check({31'h0, IRQ}, 32'h0);
    wr(`OFS_IRQ_MASK, 8'h02);
    repeat (2) @(posedge CORE_CLK);
    check({31'h0, IRQ}, 32'h1);
    rdchk(`OFS_IRQ_ST, 32'h2);
    repeat (2) @(posedge CORE_CLK);
    check({31'h0, IRQ}, 32'h0);
    $display("test stop_scl_collision done");
    wr(`OFS_IRQ_MASK, 8'h03);
    run_stop(2'd2);
    check({31'h0, IRQ}, 32'h1);
    check({31'h0, (gap >= 8 && gap <= 16)}, 32'h1);
    rdchk(`OFS_IRQ_ST, 32'h1);
    rdchk(`OFS_STAT, 32'h10);
    rdchk(`OFS_CTL1, 32'hA8);
    rdchk(`OFS_BUF, 32'h5A);
    wr(`OFS_CTL1, 8'h28);
    rdchk(`OFS_CTL1, 32'h28);
    $display("test stop_good done");
    conclude();
  end
endmodule
